//--- hdl/lmfc_align_pkg.sv
package lmfc_align_pkg;

    // register byte offsets
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] timing_offset = 8'h04;
    localparam logic [7:0] status_offset = 8'h08;
    localparam logic [7:0] reset_offset = 8'h0c;
    localparam logic [7:0] octets_offset = 8'h10;

    // timing pulse handling register fields
    localparam int realign_every_bit = 0;
    localparam int resync_needs_bit = 1;
    localparam int delay_lsb = 8;
    localparam int delay_w = 4;

    // control register fields
    localparam int ila_enable_bit = 0;
    localparam int tx_mode_bit = 1;

    // reset values
    localparam logic realign_every_rst = 1'b0;
    localparam logic resync_needs_rst = 1'b0;
    localparam logic [3:0] delay_rst = 4'h0;
    localparam logic ila_enable_rst = 1'b1;
    localparam logic tx_mode_rst = 1'b0;
    localparam logic [7:0] octets_rst = 8'h20;

    // four octets pass per core clock
    localparam logic [7:0] octets_per_clk = 8'h04;

    // datapath reset pulse length in core clocks
    localparam logic [3:0] sw_reset_cycles = 4'h8;

    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef enum logic [2:0] {
        st_reset,
        st_wait_pulse,
        st_wait_sync,
        st_wait_boundary,
        st_running
    } link_state_t;

endpackage

//--- hdl/lmfc_align.sv
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps

module lmfc_align
    import lmfc_align_pkg::*;
#(
    parameter bit capture_falling = 1'b1
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic timing_pulse,
    input wire logic sync_n_in,
    input wire logic code_sync_ok,
    input wire logic lanes_valid,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic sync_n_out,
    output logic start_ila,
    output logic start_data,
    output logic rx_release,
    output logic lmfc_boundary,
    output logic datapath_rst_n
);

    typedef struct packed {
        logic realign_every, resync_needs, ila_enable, tx_mode, aligned, link_up;
        logic aw_seen, w_seen, awready, wready, bvalid, arready, rvalid;
        logic sync1, sync2, sync_prev, code1, code2, lanes1, lanes2;
        logic pulse_s1, pulse_s2, pulse_prev;
        logic sync_n_out, start_ila, start_data, rx_release, boundary, rst_n;
        logic [1:0] bresp, rresp;
        logic [3:0] delay, w_strb, rst_cnt;
        logic [7:0] octets, aw_addr, lmfc_cnt, event_cnt;
        logic [15:0] delay_line;
        logic [31:0] w_data, rdata;
        link_state_t state;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic pulse_cap_q;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        return (a == ctrl_offset) || (a == timing_offset) || (a == status_offset) ||
               (a == reset_offset) || (a == octets_offset);
    endfunction

    // first capture flop on the chosen edge, everything later on rising
    generate
        if (capture_falling)
        begin : g_fall
            always_ff @(negedge clk or negedge rstn)
            begin
                if (!rstn)
                    pulse_cap_q <= 1'b0;
                else if (ce)
                    pulse_cap_q <= timing_pulse;
            end
        end
        else
        begin : g_rise
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    pulse_cap_q <= 1'b0;
                else if (ce)
                    pulse_cap_q <= timing_pulse;
            end
        end
    endgenerate

    always_comb
    begin
        logic event_raw, event_del, wr_fire, take_align, sw_rst;
        logic [31:0] wv;
        logic [7:0] last_oct;
        event_raw = 1'b0;
        event_del = 1'b0;
        wr_fire = 1'b0;
        wv = 32'h0;
        last_oct = 8'h0;
        take_align = 1'b0;
        sw_rst = 1'b0;
        s_d = s_q;
        // sync_n and status pins come from the partner side
        s_d.sync1 = sync_n_in;
        s_d.sync2 = s_q.sync1;
        s_d.sync_prev = s_q.sync2;
        s_d.code1 = code_sync_ok;
        s_d.code2 = s_q.code1;
        s_d.lanes1 = lanes_valid;
        s_d.lanes2 = s_q.lanes1;
        // two rising samples of the captured pulse
        s_d.pulse_s1 = pulse_cap_q;
        s_d.pulse_s2 = s_q.pulse_s1;
        s_d.pulse_prev = s_q.pulse_s2;
        event_raw = s_q.pulse_s2 && !s_q.pulse_prev;
        // tap 0 gives no extra delay
        s_d.delay_line = {s_q.delay_line[14:0], event_raw};
        event_del = (s_q.delay == 4'h0) ? event_raw : s_q.delay_line[s_q.delay - 4'h1];
        // write channel: address and data may arrive in either order
        s_d.awready = 1'b0;
        s_d.wready = 1'b0;
        if (s_axi_awvalid && s_q.awready)
        begin
            s_d.aw_seen = 1'b1;
            s_d.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_q.wready)
        begin
            s_d.w_seen = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (!s_q.aw_seen && !s_q.awready && !s_q.bvalid && s_axi_awvalid)
            s_d.awready = 1'b1;
        if (!s_q.w_seen && !s_q.wready && !s_q.bvalid && s_axi_wvalid)
            s_d.wready = 1'b1;
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        s_d.rst_n = 1'b1;
        if (s_q.aw_seen && s_q.w_seen && !s_q.bvalid)
        begin
            wr_fire = 1'b1;
            s_d.aw_seen = 1'b0;
            s_d.w_seen = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = addr_known(s_q.aw_addr) ? resp_okay : resp_slverr;
        end
        if (wr_fire)
        begin
            case (s_q.aw_addr)
                ctrl_offset:
                begin
                    wv = apply_strb({30'h0, s_q.tx_mode, s_q.ila_enable}, s_q.w_data, s_q.w_strb);
                    s_d.ila_enable = wv[ila_enable_bit];
                    s_d.tx_mode = wv[tx_mode_bit];
                end
                timing_offset:
                begin
                    wv = apply_strb({20'h0, s_q.delay, 6'h0, s_q.resync_needs, s_q.realign_every},
                                    s_q.w_data, s_q.w_strb);
                    s_d.realign_every = wv[realign_every_bit];
                    s_d.resync_needs = wv[resync_needs_bit];
                    s_d.delay = wv[delay_lsb +: delay_w];
                end
                reset_offset:
                begin
                    // applied after the state machine so no transition can swallow it
                    sw_rst = s_q.w_strb[0] && s_q.w_data[0];
                end
                octets_offset:
                begin
                    wv = apply_strb({24'h0, s_q.octets}, s_q.w_data, s_q.w_strb);
                    s_d.octets = wv[7:0];
                end
                default: wv = 32'h0;
            endcase
        end
        // read channel
        s_d.arready = 1'b0;
        if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        if (s_axi_arvalid && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = addr_known(s_axi_araddr[7:0]) ? resp_okay : resp_slverr;
            case (s_axi_araddr[7:0])
                ctrl_offset: s_d.rdata = {30'h0, s_q.tx_mode, s_q.ila_enable};
                timing_offset: s_d.rdata = {20'h0, s_q.delay, 6'h0, s_q.resync_needs,
                                            s_q.realign_every};
                status_offset: s_d.rdata = {16'h0, s_q.event_cnt, 2'h0, s_q.link_up,
                                            s_q.aligned, 1'b0, 3'(s_q.state)};
                octets_offset: s_d.rdata = {24'h0, s_q.octets};
                default: s_d.rdata = 32'h0;
            endcase
        end
        else if (!s_q.arready && !s_q.rvalid && s_axi_arvalid)
            s_d.arready = 1'b1;
        // multiframe counter in octets, four per clock
        last_oct = s_q.octets - octets_per_clk;
        s_d.boundary = 1'b0;
        take_align = event_del && (s_q.realign_every || !s_q.aligned);
        if (take_align)
        begin
            s_d.lmfc_cnt = 8'h0;
            s_d.aligned = 1'b1;
        end
        else if (s_q.lmfc_cnt >= last_oct)
        begin
            s_d.lmfc_cnt = 8'h0;
            s_d.boundary = 1'b1;
        end
        else
            s_d.lmfc_cnt = s_q.lmfc_cnt + octets_per_clk;
        if (event_raw)
            s_d.event_cnt = s_q.event_cnt + 8'h1;
        s_d.start_ila = 1'b0;
        s_d.start_data = 1'b0;
        s_d.rx_release = 1'b0;
        case (s_q.state)
            st_reset:
            begin
                s_d.rst_n = 1'b0;
                s_d.sync_n_out = 1'b0;
                s_d.link_up = 1'b0;
                s_d.aligned = 1'b0;
                s_d.rst_cnt = s_q.rst_cnt + 4'h1;
                if (s_q.rst_cnt == sw_reset_cycles - 4'h1)
                begin
                    s_d.rst_cnt = 4'h0;
                    s_d.state = st_wait_pulse;
                end
            end
            st_wait_pulse:
            begin
                // hold sync_n low until the counter has been aligned
                s_d.sync_n_out = 1'b0;
                if (s_q.aligned)
                    s_d.state = st_wait_sync;
            end
            st_wait_sync:
            begin
                if (!s_q.tx_mode && s_q.code2 && s_q.boundary)
                begin
                    s_d.sync_n_out = 1'b1;
                    s_d.state = st_wait_boundary;
                end
                else if (s_q.tx_mode && s_q.sync2)
                    s_d.state = st_wait_boundary;
            end
            st_wait_boundary:
            begin
                if (s_q.boundary)
                begin
                    if (s_q.tx_mode)
                    begin
                        s_d.start_ila = s_q.ila_enable;
                        s_d.start_data = !s_q.ila_enable;
                        s_d.link_up = 1'b1;
                        s_d.state = st_running;
                    end
                    else if (s_q.lanes2)
                    begin
                        s_d.rx_release = 1'b1;
                        s_d.link_up = 1'b1;
                        s_d.state = st_running;
                    end
                end
            end
            st_running:
            begin
                if (s_q.tx_mode ? (s_q.sync_prev && !s_q.sync2) : !s_q.code2)
                begin
                    // resync request by the receiving end
                    s_d.sync_n_out = 1'b0;
                    s_d.link_up = 1'b0;
                    if (s_q.resync_needs)
                    begin
                        s_d.aligned = take_align;
                        s_d.state = st_wait_pulse;
                    end
                    else
                        s_d.state = st_wait_sync;
                end
            end
            default: s_d.state = st_reset;
        endcase
        if (sw_rst)
        begin
            s_d.state = st_reset;
            s_d.rst_cnt = 4'h0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.realign_every <= realign_every_rst;
            s_q.resync_needs <= resync_needs_rst;
            s_q.delay <= delay_rst;
            s_q.ila_enable <= ila_enable_rst;
            s_q.tx_mode <= tx_mode_rst;
            s_q.octets <= octets_rst;
            s_q.state <= st_reset;
            s_q.sync1 <= 1'b1;
            s_q.sync2 <= 1'b1;
            s_q.sync_prev <= 1'b1;
            s_q.bresp <= resp_okay;
            s_q.rresp <= resp_okay;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign sync_n_out = s_q.sync_n_out;
    assign start_ila = s_q.start_ila;
    assign start_data = s_q.start_data;
    assign rx_release = s_q.rx_release;
    assign lmfc_boundary = s_q.boundary;
    assign datapath_rst_n = s_q.rst_n;

endmodule

//--- testbench/lmfc_align_properties.sv
`timescale 1ns/10ps
module lmfc_align_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic timing_pulse,
    input wire logic sync_n_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sync_n_out,
    input wire logic start_ila,
    input wire logic start_data,
    input wire logic rx_release,
    input wire logic lmfc_boundary,
    input wire logic datapath_rst_n
);
    logic seen_q;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // loose: a software reset is not tracked here
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            seen_q <= 1'b0;
        else if (timing_pulse)
            seen_q <= 1'b1;
    end
    AST_BOUNDARY_SINGLE: assert property (lmfc_boundary |=> !lmfc_boundary)
        else $error("boundary pulse too long");
    AST_ILA_ON_BOUNDARY: assert property (start_ila |-> lmfc_boundary || $past(lmfc_boundary))
        else $error("ila start off boundary");
    AST_DATA_ON_BOUNDARY: assert property (start_data |-> !start_ila
        && (lmfc_boundary || $past(lmfc_boundary))) else $error("data start off boundary");
    AST_RELEASE_ON_BOUNDARY: assert property (rx_release |-> lmfc_boundary || $past(lmfc_boundary))
        else $error("release off boundary");
    AST_SYNC_ON_BOUNDARY: assert property ($rose(sync_n_out) |-> lmfc_boundary || $past(lmfc_boundary))
        else $error("sync release off boundary");
    AST_NO_LINK_UNALIGNED: assert property (sync_n_out || start_ila || start_data |-> seen_q)
        else $error("link up without alignment");
    AST_NO_START_SYNC_LOW: assert property (!sync_n_in [*6] |-> !(start_ila || start_data))
        else $error("start while sync low");
    AST_DP_RESET_LEN: assert property ($fell(datapath_rst_n) |-> !datapath_rst_n [*7] ##[1:3] datapath_rst_n)
        else $error("datapath reset length wrong");
    AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

bind lmfc_align lmfc_align_properties u_lmfc_align_properties (.clk, .rstn, .timing_pulse, .sync_n_in,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sync_n_out,
    .start_ila, .start_data, .rx_release, .lmfc_boundary, .datapath_rst_n);

//--- testbench/link_partner.sv
`timescale 1ns/10ps
module link_partner (
    input wire logic clk,
    input wire logic fire,
    input wire logic rx_ready,
    output logic timing_pulse,
    output logic sync_n_in,
    output logic code_sync_ok,
    output logic lanes_valid
);
    logic [2:0] n_q = 3'h0;
    // one-shot, four clocks wide, sent only on request after reset
    always @(posedge clk)
    begin
        if (fire)
            n_q <= 3'h4;
        else if (n_q != 3'h0)
            n_q <= n_q - 3'h1;
    end
    assign timing_pulse = n_q != 3'h0;
    // dropping ready asks the core to resync
    assign sync_n_in = rx_ready;
    assign code_sync_ok = rx_ready;
    assign lanes_valid = rx_ready;
endmodule

//--- testbench/lmfc_align_tb_top.sv
`timescale 1ns/10ps
module lmfc_align_tb_top;
    import lmfc_align_pkg::*;
    logic clk, rstn, ce, fire, rx_ready, timing_pulse, sync_n_in, code_sync_ok, lanes_valid;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic sync_n_out, start_ila, start_data, rx_release, lmfc_boundary, datapath_rst_n;
    int n_errors, n_tests, cyc, c_sync, c_ila, c_data, c_rel, k, p;
    lmfc_align u_lmfc_align (.clk, .rstn, .ce, .timing_pulse, .sync_n_in, .code_sync_ok,
        .lanes_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sync_n_out, .start_ila, .start_data, .rx_release, .lmfc_boundary, .datapath_rst_n);
    link_partner u_link_partner (.clk, .fire, .rx_ready, .timing_pulse, .sync_n_in,
        .code_sync_ok, .lanes_valid);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sync_n_out === 1'b1) c_sync <= c_sync + 1;
        if (start_ila === 1'b1) c_ila <= c_ila + 1;
        if (start_data === 1'b1) c_data <= c_data + 1;
        if (rx_release === 1'b1) c_rel <= c_rel + 1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge clk);
            if (s_axi_awready === 1'b1)
            begin
                s_axi_awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (s_axi_wready === 1'b1)
            begin
                s_axi_wvalid <= 1'b0;
                w = 1'b1;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    task automatic wt(ref int c, input int lim, input logic exp);
        int s;
        int i;
        s = c;
        i = 0;
        while (c == s && i < lim)
        begin
            @(posedge clk);
            i++;
        end
        chk({31'h0, c != s}, {31'h0, exp});
    endtask
    // fixed phase of the pulse, so boundary phase shows the delay
    task pulse();
        do @(posedge clk); while (datapath_rst_n !== 1'b1 || cyc % 8 != 0);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    task ph(output int q);
        repeat (30) @(posedge clk);
        do @(posedge clk); while (lmfc_boundary !== 1'b1);
        q = cyc % 8;
    endtask
    task results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ample margin over the well under 1000 clocks the tests need
    initial
    begin
        #200000;
        n_errors++;
        results();
    end
    initial
    begin
        {rstn, fire, rx_ready, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 'h0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        axr(ctrl_offset, {30'h0, tx_mode_rst, ila_enable_rst}, resp_okay);
        axr(timing_offset, {20'h0, delay_rst, 6'h0, resync_needs_rst, realign_every_rst}, resp_okay);
        axr(octets_offset, {24'h0, octets_rst}, resp_okay);
        axr(8'h40, 32'h0, resp_slverr);
        axw(8'h40, 32'hffff_ffff, resp_slverr);
        $display("register test done");
        rx_ready <= 1'b1;
        wt(c_sync, 40, 1'b0);
        pulse();
        wt(c_rel, 60, 1'b1);
        ph(k);
        wt(c_sync, 40, 1'b1);
        axr(status_offset, {16'h0, 8'h01, 2'h0, 1'b1, 1'b1, 1'b0, 3'(st_running)}, resp_okay);
        axw(status_offset, 32'h0, resp_okay);
        $display("rx bring-up test done");
        axw(timing_offset, 32'h300, resp_okay);
        pulse();
        ph(p);
        chk(p, k);
        // two frozen clocks push every later boundary two cycles back
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        ph(p);
        chk(p, (k + 2) % 8);
        axw(timing_offset, 32'h301, resp_okay);
        pulse();
        ph(p);
        chk(p, (k + 3) % 8);
        axw(timing_offset, 32'hf00, resp_okay);
        axw(reset_offset, 32'h1, resp_okay);
        axr(timing_offset, 32'hf00, resp_okay);
        pulse();
        ph(p);
        chk(p, (k + 15) % 8);
        $display("realign and delay test done");
        rx_ready <= 1'b0;
        repeat (10) @(posedge clk);
        chk({31'h0, sync_n_out}, 32'h0);
        rx_ready <= 1'b1;
        wt(c_sync, 40, 1'b1);
        axw(timing_offset, 32'h2, resp_okay);
        rx_ready <= 1'b0;
        repeat (10) @(posedge clk);
        rx_ready <= 1'b1;
        wt(c_sync, 40, 1'b0);
        pulse();
        wt(c_sync, 60, 1'b1);
        $display("rx resync test done");
        axw(ctrl_offset, 32'h3, resp_okay);
        axw(timing_offset, 32'h0, resp_okay);
        axw(reset_offset, 32'h1, resp_okay);
        wt(c_ila, 40, 1'b0);
        pulse();
        wt(c_ila, 60, 1'b1);
        axw(ctrl_offset, 32'h2, resp_okay);
        rx_ready <= 1'b0;
        repeat (10) @(posedge clk);
        rx_ready <= 1'b1;
        wt(c_data, 40, 1'b1);
        $display("tx start test done");
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        axr(ctrl_offset, {30'h0, tx_mode_rst, ila_enable_rst}, resp_okay);
        $display("bus reset test done");
        results();
    end
endmodule
